// >>> ndc_direct_command_decoder.sv
// ndc_direct_command_decoder.sv: decodes one-byte direct commands, checks
// the operation control bits, and pulses the matching action line.
// assumes: register port master per house bus; long actions report done.
//
// Implementation choices: the register offsets and the strobed register port.
`include "ndc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module ndc_direct_command_decoder
(
  // clock and reset
  input  wire logic                      SYS_CLK,
  input  wire logic                      RST_N,
  // register port
  input  wire logic [3:0]                REG_ADDR,
  input  wire logic [7:0]                REG_WDATA,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  output var  logic [7:0]                REG_RDATA,
  // action strobes, one bit per command slot
  output var  logic [`NDC_ACT_W-1:0]     ACT_PULSE,
  // completion of long-running actions
  input  wire logic                      ACT_DONE,
  // command end interrupt request pulse
  output var  logic                      CMD_IRQ,
  // oscillator held on for a power-down measurement
  output var  logic                      OSC_TEMP_EN,
  // level outputs
  output var  logic                      CHAIN_OK,
  output var  logic                      BUSY
);

  // ---------------------------------------------------------------
  // decode table
  // ---------------------------------------------------------------
  // per code: slot, needs en, rx_en, tx_en, no-wakeup, chain, irq
  logic [7:0] opctl;
  logic [7:0] status;
  ndc_pkg::ndc_state_e state;
  logic [`NDC_ACT_W_LOG-1:0] run_slot;
  logic                      run_irq;
  logic                      run_osc;

  wire        cmd_wr   = REG_WR && (REG_ADDR == `NDC_REG_CMD);
  wire        opctl_wr = REG_WR && (REG_ADDR == `NDC_REG_OPCTL);
  wire [7:0]  code     = REG_WDATA;

  logic [`NDC_ACT_W_LOG-1:0] d_slot;
  logic d_valid, d_en, d_rx, d_tx, d_nowu, d_chain, d_irq, d_all;

  // table, unassigned codes fall to not valid
  always_comb
  begin
    d_valid = 1'b1;
    d_slot  = '0;
    d_en    = 1'b1;
    d_rx    = 1'b0;
    d_tx    = 1'b0;
    d_nowu  = 1'b0;
    d_chain = 1'b1;
    d_irq   = 1'b0;
    d_all   = 1'b0;
    case (code)
      `NDC_CMD_DEFAULT_A, `NDC_CMD_DEFAULT_B:
      begin
        d_slot = 5'd0; d_all = 1'b1; d_chain = 1'b0;
      end
      `NDC_CMD_STOP_A, `NDC_CMD_STOP_B: d_slot = 5'd1;
      `NDC_CMD_TX_CRC:    d_slot = 5'd2;
      `NDC_CMD_TX_NOCRC:  d_slot = 5'd3;
      `NDC_CMD_TX_REQA:
      begin
        d_slot = 5'd4; d_tx = 1'b1;
      end
      `NDC_CMD_TX_WUPA:
      begin
        d_slot = 5'd5; d_tx = 1'b1;
      end
      `NDC_CMD_FLD_INIT:
      begin
        d_slot = 5'd6; d_irq = 1'b1;
      end
      `NDC_CMD_FLD_RESP:
      begin
        d_slot = 5'd7; d_irq = 1'b1;
      end
      `NDC_CMD_SENSE:
      begin
        d_slot = 5'd8; d_rx = 1'b1;
      end
      `NDC_CMD_SLEEP:
      begin
        d_slot = 5'd9; d_rx = 1'b1;
      end
      `NDC_CMD_MASK_RX:
      begin
        d_slot = 5'd10; d_all = 1'b1;
      end
      `NDC_CMD_UNMASK_RX:
      begin
        d_slot = 5'd11; d_all = 1'b1;
      end
      `NDC_CMD_AM_TOGGLE:
      begin
        d_slot = 5'd12; d_tx = 1'b1;
      end
      `NDC_CMD_MEAS_AMP:
      begin
        d_slot = 5'd13; d_all = 1'b1; d_chain = 1'b0; d_irq = 1'b1;
      end
      `NDC_CMD_RX_GAIN:
      begin
        d_slot = 5'd14; d_chain = 1'b0;
      end
      `NDC_CMD_ADJ_REG:
      begin
        d_slot = 5'd15; d_chain = 1'b0; d_irq = 1'b1;
      end
      `NDC_CMD_CAL_DRV:
      begin
        d_slot = 5'd16; d_chain = 1'b0;
      end
      `NDC_CMD_MEAS_PHASE:
      begin
        d_slot = 5'd17; d_all = 1'b1; d_chain = 1'b0; d_irq = 1'b1;
      end
      `NDC_CMD_CLR_RSSI:  d_slot = 5'd18;
      `NDC_CMD_CLR_FIFO:  d_slot = 5'd19;
      `NDC_CMD_TRANSP:
      begin
        d_slot = 5'd20; d_chain = 1'b0;
      end
      `NDC_CMD_CAL_CAP:
      begin
        d_slot = 5'd21; d_all = 1'b1; d_chain = 1'b0; d_irq = 1'b1;
      end
      `NDC_CMD_MEAS_CAP:
      begin
        d_slot = 5'd22; d_all = 1'b1; d_chain = 1'b0; d_irq = 1'b1;
      end
      `NDC_CMD_MEAS_SUP:
      begin
        d_slot = 5'd23; d_chain = 1'b0; d_irq = 1'b1;
      end
      `NDC_CMD_TMR_GP:    d_slot = 5'd24;
      `NDC_CMD_TMR_WAKE:
      begin
        d_slot = 5'd25; d_all = 1'b1; d_nowu = 1'b1;
      end
      `NDC_CMD_TMR_MASK:  d_slot = 5'd26;
      `NDC_CMD_TMR_NRSP:  d_slot = 5'd27;
      `NDC_CMD_TMR_PEER:  d_slot = 5'd28;
      `NDC_CMD_TMR_NRSTOP: d_slot = 5'd29;
      `NDC_CMD_SPACE_B:
      begin
        d_slot = 5'd30; d_all = 1'b1;
      end
      `NDC_CMD_TEST:
      begin
        d_slot = 5'd31; d_all = 1'b1;
      end
      default: d_valid = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // acceptance
  // ---------------------------------------------------------------
  // operation bits gate acceptance
  wire need_ok = d_all ||
                 ((!d_en || opctl[`NDC_OP_EN]) &&
                  (!d_rx || opctl[`NDC_OP_RX_EN]) &&
                  (!d_tx || opctl[`NDC_OP_TX_EN]));
  // wake-up timer refused in wakeup mode
  wire wu_ok   = !(d_nowu && opctl[`NDC_OP_WAKEUP]);
  // further commands while a long one runs are dropped
  wire idle    = (state == ndc_pkg::NDC_IDLE);
  wire accept  = cmd_wr && d_valid && need_ok && wu_ok && idle;
  wire refuse  = cmd_wr && !accept;
  // set default also clears operation control
  wire do_dflt = accept && (d_slot == 5'd0);
  // oscillator held on while measuring amplitude or phase in power-down
  wire osc_tmp = accept && !opctl[`NDC_OP_EN] &&
                 ((d_slot == 5'd13) || (d_slot == 5'd17));

  // ---------------------------------------------------------------
  // action strobes
  // ---------------------------------------------------------------
  // one decode per slot; a single register keeps one driver on the port
  wire [`NDC_ACT_W-1:0] next_act;
  genvar gi;
  generate
    for (gi = 0; gi < `NDC_ACT_W; gi++)
    begin : g_act
      assign next_act[gi] = accept && (d_slot == (`NDC_ACT_W_LOG)'(gi));
    end
  endgenerate

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      ACT_PULSE <= '0;
    else
      ACT_PULSE <= next_act;
  end

  // ---------------------------------------------------------------
  // sequencing of long commands
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      state    <= ndc_pkg::NDC_IDLE;
      run_slot <= '0;
      run_irq  <= 1'b0;
      run_osc  <= 1'b0;
    end
    else if (state == ndc_pkg::NDC_IDLE)
    begin
      // irq commands hold busy until done
      if (accept && d_irq)
        state <= ndc_pkg::NDC_RUN;
      if (accept)
      begin
        run_slot <= d_slot;
        run_irq  <= d_irq;
        run_osc  <= osc_tmp;
      end
    end
    else if (ACT_DONE)
    begin
      state   <= ndc_pkg::NDC_IDLE;
      run_osc <= 1'b0;
    end
  end

  wire finish = (state == ndc_pkg::NDC_RUN) && ACT_DONE;

  // ---------------------------------------------------------------
  // registers and outputs
  // ---------------------------------------------------------------
  wire [7:0] next_status = {
    (accept && (d_slot == 5'd20)) | status[`NDC_ST_TRANSP],
    (accept && (d_slot == 5'd31)) | status[`NDC_ST_TEST],
    (accept && (d_slot == 5'd30)) | status[`NDC_ST_SPACE_B],
    osc_tmp | (run_osc && !finish),
    refuse,
    accept ? d_irq : status[`NDC_ST_IRQ_END],
    accept ? d_chain : status[`NDC_ST_CHAIN],
    (accept && d_irq) | (!idle && !finish)
  };

  wire [7:0] rd_mux =
    (REG_ADDR == `NDC_REG_OPCTL)  ? opctl :
    (REG_ADDR == `NDC_REG_STATUS) ? status :
    (REG_ADDR == `NDC_REG_DONE)   ? {3'h0, run_slot} : 8'h00;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N || do_dflt)
    begin
      opctl       <= `NDC_OPCTL_RESET;
      status      <= 8'h00;
      REG_RDATA   <= 8'h00;
      CMD_IRQ     <= 1'b0;
      OSC_TEMP_EN <= 1'b0;
      CHAIN_OK    <= 1'b0;
      BUSY        <= 1'b0;
    end
    else
    begin
      if (opctl_wr)
        opctl <= REG_WDATA;
      status      <= next_status;
      REG_RDATA   <= REG_RD ? rd_mux : 8'h00;
      // interrupt on completion of long command
      CMD_IRQ     <= finish && run_irq;
      OSC_TEMP_EN <= next_status[`NDC_ST_OSC_TEMP];
      // chain flag follows last accepted command
      CHAIN_OK    <= next_status[`NDC_ST_CHAIN];
      BUSY        <= next_status[`NDC_ST_BUSY];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_reserved_quiet;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (cmd_wr && !d_valid) |=> (ACT_PULSE == '0);
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet)
    else $error("reserved code produced an action");

  property p_en_gate;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (cmd_wr && code == `NDC_CMD_TX_CRC && !opctl[`NDC_OP_EN]) |=>
      !ACT_PULSE[2];
  endproperty
  a_en_gate: assert property (p_en_gate)
    else $error("transmit accepted without en");

  property p_tx_gate;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (cmd_wr && code == `NDC_CMD_TX_REQA && !opctl[`NDC_OP_TX_EN]) |=>
      !ACT_PULSE[4];
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("REQA accepted without tx_en");

  property p_rx_gate;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (cmd_wr && code == `NDC_CMD_SLEEP && !opctl[`NDC_OP_RX_EN]) |=>
      !ACT_PULSE[9];
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("sleep accepted without rx_en");

  property p_wake_refused;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (cmd_wr && code == `NDC_CMD_TMR_WAKE && opctl[`NDC_OP_WAKEUP]) |=>
      !ACT_PULSE[25];
  endproperty
  a_wake_refused: assert property (p_wake_refused)
    else $error("wake-up timer started in wakeup mode");

  property p_mask_any;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (cmd_wr && idle && code == `NDC_CMD_MASK_RX) |=> ACT_PULSE[10];
  endproperty
  a_mask_any: assert property (p_mask_any)
    else $error("mask receive not accepted");

  property p_irq_end;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (state == ndc_pkg::NDC_RUN && ACT_DONE && run_irq) |=> CMD_IRQ;
  endproperty
  a_irq_end: assert property (p_irq_end)
    else $error("no interrupt at completion");

  property p_no_chain_meas;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (accept && code == `NDC_CMD_MEAS_AMP) |=> (!CHAIN_OK && BUSY);
  endproperty
  a_no_chain_meas: assert property (p_no_chain_meas)
    else $error("amplitude measure chainable or not busy");

  property p_osc_temp;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (accept && code == `NDC_CMD_MEAS_PHASE && !opctl[`NDC_OP_EN]) |=>
      OSC_TEMP_EN;
  endproperty
  a_osc_temp: assert property (p_osc_temp)
    else $error("oscillator not held for measurement");

  property p_dflt;
    @(posedge SYS_CLK) disable iff (!RST_N)
    do_dflt |=> (opctl == `NDC_OPCTL_RESET && !CMD_IRQ);
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("set default left state");

  c_long: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && d_irq ##[1:20] CMD_IRQ);
  c_refuse: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    refuse);
  c_chain: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    accept && d_chain ##1 accept);

endmodule : ndc_direct_command_decoder
`default_nettype wire

// >>> ndc_regs.svh
// ndc_regs.svh: command codes, register offsets and field positions of the
// direct command decoder.
// assumes: included by the decoder module and the action model only.
`ifndef NDC_REGS_SVH
`define NDC_REGS_SVH

// command codes
`define NDC_CMD_DEFAULT_A   8'hc0
`define NDC_CMD_DEFAULT_B   8'hc1
`define NDC_CMD_STOP_A      8'hc2
`define NDC_CMD_STOP_B      8'hc3
`define NDC_CMD_TX_CRC      8'hc4
`define NDC_CMD_TX_NOCRC    8'hc5
`define NDC_CMD_TX_REQA     8'hc6
`define NDC_CMD_TX_WUPA     8'hc7
`define NDC_CMD_FLD_INIT    8'hc8
`define NDC_CMD_FLD_RESP    8'hc9
`define NDC_CMD_SENSE       8'hcd
`define NDC_CMD_SLEEP       8'hce
`define NDC_CMD_MASK_RX     8'hd0
`define NDC_CMD_UNMASK_RX   8'hd1
`define NDC_CMD_AM_TOGGLE   8'hd2
`define NDC_CMD_MEAS_AMP    8'hd3
`define NDC_CMD_RX_GAIN     8'hd5
`define NDC_CMD_ADJ_REG     8'hd6
`define NDC_CMD_CAL_DRV     8'hd8
`define NDC_CMD_MEAS_PHASE  8'hd9
`define NDC_CMD_CLR_RSSI    8'hda
`define NDC_CMD_CLR_FIFO    8'hdb
`define NDC_CMD_TRANSP      8'hdc
`define NDC_CMD_CAL_CAP     8'hdd
`define NDC_CMD_MEAS_CAP    8'hde
`define NDC_CMD_MEAS_SUP    8'hdf
`define NDC_CMD_TMR_GP      8'he0
`define NDC_CMD_TMR_WAKE    8'he1
`define NDC_CMD_TMR_MASK    8'he2
`define NDC_CMD_TMR_NRSP    8'he3
`define NDC_CMD_TMR_PEER    8'he4
`define NDC_CMD_TMR_NRSTOP  8'he8
`define NDC_CMD_SPACE_B     8'hfb
`define NDC_CMD_TEST        8'hfc

// register offsets
`define NDC_REG_CMD         4'h0
`define NDC_REG_OPCTL       4'h1
`define NDC_REG_STATUS      4'h2
`define NDC_REG_DONE        4'h3

// operation control bits
`define NDC_OP_EN           0
`define NDC_OP_RX_EN        1
`define NDC_OP_TX_EN        2
`define NDC_OP_WAKEUP       3
`define NDC_OPCTL_RESET     8'h00

// status bits
`define NDC_ST_BUSY         0
`define NDC_ST_CHAIN        1
`define NDC_ST_IRQ_END      2
`define NDC_ST_REFUSED      3
`define NDC_ST_OSC_TEMP     4
`define NDC_ST_SPACE_B      5
`define NDC_ST_TEST         6
`define NDC_ST_TRANSP       7

// one-hot action vector width
`define NDC_ACT_W           32
`define NDC_ACT_W_LOG       5

`endif

// >>> ndc_pkg.sv
// ndc_pkg.sv: types of the direct command decoder.
// assumes: ndc_regs.svh is in the include path.
`default_nettype none
package ndc_pkg;
  typedef enum logic [1:0] {
    NDC_IDLE = 2'b00,
    NDC_RUN  = 2'b01
  } ndc_state_e;
endpackage : ndc_pkg
`default_nettype wire

// >>> ndc_action_model.sv
// ndc_action_model.sv: behavioural model of the long-running action units.
// assumes: one long action at a time; done pulse follows a slot pulse.
`timescale 1ns/10ps
`default_nettype none
`include "ndc_regs.svh"

module ndc_action_model
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // action slots and answer delay
  input  wire logic [`NDC_ACT_W-1:0] act_pulse,
  input  wire logic [7:0]            delay,
  // completion
  output var  logic                  act_done
);
  // slots of C8 C9 D3 D6 D9 DD DE DF
  localparam logic [31:0] LONG_SLOTS = 32'h00e2a0c0;

  logic       run;
  logic [7:0] cnt;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      run      <= 1'b0;
      cnt      <= 8'h00;
      act_done <= 1'b0;
    end
    else
    begin
      act_done <= 1'b0;
      if (|(act_pulse & LONG_SLOTS))
      begin
        run <= 1'b1;
        cnt <= delay;
      end
      else if (run && cnt == 8'h00)
      begin
        act_done <= 1'b1;
        run      <= 1'b0;
      end
      else if (run)
        cnt <= cnt - 8'h01;
    end
  end
endmodule : ndc_action_model
`default_nettype wire

// >>> tb_ndc.sv
// tb_ndc.sv: self-checking bench of the direct command decoder.
// assumes: design and action model compiled first, header on include path.
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        sys_clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [31:0] act_pulse;
  logic        act_done;
  logic        cmd_irq;
  logic        osc_temp_en;
  logic        chain_ok;
  logic        busy;
  logic [7:0]  delay;
  int          fails;
  int          n_compared;
  logic [31:0] rows [53];

  ndc_direct_command_decoder dut_u (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .ACT_PULSE(act_pulse), .ACT_DONE(act_done),
    .CMD_IRQ(cmd_irq), .OSC_TEMP_EN(osc_temp_en), .CHAIN_OK(chain_ok),
    .BUSY(busy));

  ndc_action_model act_u (
    .clk(sys_clk), .rst_n(rst_n), .act_pulse(act_pulse), .delay(delay),
    .act_done(act_done));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // bounded, since a lost done would hang the host forever
  task automatic wait_irq;
    int i;
    for (i = 0; i < 100; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (cmd_irq === 1'b1)
        break;
    end
    if (i == 100)
    begin
      fails++;
      test_done();
    end
  endtask : wait_irq

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0]  d;
    logic [31:0] r;
    logic        exp_chain;
    logic        osc;
    fails = 0;
    n_compared = 0;
    exp_chain = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    delay = 8'h02;
    rst_n = 1'b0;
    // rows: opctl, code, slot, flags (accept, chain, long)
    rows = '{32'h07c00001, 32'h00c10001, 32'h01c20103, 32'h01c30103,
      32'h01c40203, 32'h01c50303, 32'h05c60403, 32'h05c70503,
      32'h01c80607, 32'h01c90707, 32'h03cd0803, 32'h03ce0903,
      32'h00d00a03, 32'h00d10b03, 32'h05d20c03, 32'h00d30d05,
      32'h01d30d05, 32'h01d50e01, 32'h01d60f05, 32'h01d81001,
      32'h00d91105, 32'h01da1203, 32'h01db1303, 32'h01dc1401,
      32'h00dd1505, 32'h00de1605, 32'h01df1705, 32'h01e01803,
      32'h00e11903, 32'h01e21a03, 32'h01e31b03, 32'h01e41c03,
      32'h01e81d03, 32'h00fb1e03, 32'h00fc1f03, 32'h00c20000,
      32'h01c60000, 32'h04c70000, 32'h01cd0000, 32'h02ce0000,
      32'h01d20000, 32'h00d50000, 32'h06df0000, 32'h00e00000,
      32'h09e10000, 32'h0ee80000, 32'h0ffa0000, 32'h0fff0000,
      32'h0f000000, 32'h0fca0000, 32'h0fd40000, 32'h00c40000,
      32'h05ce0000};
    repeat (8) @(posedge sys_clk);
    #1;
    chk({reg_rdata, act_pulse[7:0], cmd_irq, osc_temp_en, chain_ok, busy},
        32'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(4'h1, d);
    chk(d, 32'h00);
    rd(4'h9, d);
    chk(d, 32'h00);

    foreach (rows[k])
    begin
      r = rows[k];
      wr(4'h1, r[31:24]);
      wr(4'h0, r[23:16]);
      #1;
      if (r[0])
        exp_chain = r[1];
      chk(act_pulse, r[0] ? (32'h1 << r[12:8]) : 32'h0);
      chk(chain_ok, exp_chain);
      chk(busy, r[0] & r[2]);
      if (r[0] & r[2])
      begin
        osc = (r[23:16] == 8'hd3 || r[23:16] == 8'hd9) && !r[24];
        chk(osc_temp_en, osc);
        wait_irq();
        chk(busy, 1'b0);
        chk(osc_temp_en, 1'b0);
        // interrupt is a single-cycle pulse
        @(posedge sys_clk);
        #1 chk(cmd_irq, 1'b0);
      end
      // last accepted slot reads back
      if (r[0])
      begin
        rd(4'h3, d);
        chk(d, r[12:8]);
      end
    end

    // ----------------------------------------------------------------
    // awkward cases
    // ----------------------------------------------------------------
    // slow partner: command during busy is dropped
    delay <= 8'h14;
    wr(4'h1, 8'h01);
    wr(4'h0, 8'hd6);
    wr(4'h0, 8'hc4);
    #1 chk(act_pulse, 32'h0);
    wait_irq();
    delay <= 8'h02;
    wr(4'h0, 8'hc4);
    #1 chk(act_pulse, 32'h4);

    // back-to-back writes, each pulse one cycle
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= 4'h0;
    reg_wdata <= 8'hd0;
    @(posedge sys_clk);
    reg_wdata <= 8'hd1;
    #1 chk(act_pulse, 32'h400);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1 chk(act_pulse, 32'h800);
    @(posedge sys_clk);
    #1 chk(act_pulse, 32'h0);

    // space-B, test and transparent stick until set default
    wr(4'h1, 8'h07);
    wr(4'h0, 8'hfb);
    wr(4'h0, 8'hfc);
    wr(4'h0, 8'hdc);
    rd(4'h2, d);
    chk(d[6:5], 2'b11);
    chk(d[7], 1'b1);
    wr(4'h0, 8'hc0);
    rd(4'h1, d);
    chk(d, 32'h00);
    rd(4'h2, d);
    chk(d, 32'h00);
    test_done();
  end
endmodule : tb
`default_nettype wire
